// File: infrared_bit_codec.sv
// infrared encoder/decoder between a uart and an infrared transceiver
`include "irbc_defs.svh"
`timescale 1ns/10ps
module infrared_bit_codec
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic uart_enable,
   input wire logic infrared_codec_enable,
   input wire logic baud_tick,
   input wire logic uart_tx,
   output logic uart_rx,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic rx_active
);
   import irbc_pkg::*;
   irbc_tick_if tick ();
   logic ir_out;
   logic codec_on_reg;
   logic in_reg;
   logic in_prev_reg;
   logic fall;
   irbc_count_t rx_cnt_reg;
   irbc_rx_state_e rx_state_reg;
   logic bit_reg;
   logic seen_reg;
   logic rx_dec_reg;
   ////////////////////////////////////////////////////////////
   // only with uart enabled; rate comes from the uart baud tick
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         codec_on_reg <= 1'b0;
      else
         codec_on_reg <= uart_enable && infrared_codec_enable;
   end
   assign tick.baud_tick = baud_tick;
   assign tick.codec_on = codec_on_reg;
   ////////////////////////////////////////////////////////////
   // transmit modulator
   irbc_encoder u_enc
   (
      .clock(clock),
      .rst_n(rst_n),
      .tick(tick),
      .uart_tx(uart_tx),
      .infrared_modulated_out(ir_out)
   );
   ////////////////////////////////////////////////////////////
   // input registered so the edge detector never sees a raw pin
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         in_reg <= 1'b1;
         in_prev_reg <= 1'b1;
      end
      else
      begin
         in_reg <= serial_in_pin;
         in_prev_reg <= in_reg;
      end
   end
   // pulses are active high on this line; the falling edge ends one
   // receive ignored while the encoder is sending a pulse bit
   assign fall = in_prev_reg && !in_reg && !tick.tx_busy;
   ////////////////////////////////////////////////////////////
   // receive counter and window state
   always_ff @(posedge clock)
   begin
      if (!rst_n || !codec_on_reg)
      begin
         rx_state_reg <= IRBC_RX_IDLE;
         rx_cnt_reg <= 4'h0;
         bit_reg <= 1'b1;
         seen_reg <= 1'b0;
      end
      else
      begin
         case (rx_state_reg)
            IRBC_RX_IDLE:
            begin
               // first edge from idle is a zero
               if (fall)
               begin
                  rx_state_reg <= IRBC_RX_BIT;
                  rx_cnt_reg <= 4'h0;
                  bit_reg <= 1'b0;
               end
            end
            IRBC_RX_BIT:
            begin
               if (fall && seen_reg)
               begin
                  rx_cnt_reg <= 4'h0;
                  bit_reg <= 1'b0;
                  seen_reg <= 1'b0;
               end
               else if (baud_tick)
               begin
                  rx_cnt_reg <= rx_cnt_reg + 4'h1;
                  if (irbc_at(rx_cnt_reg, `IRBC_RX_WIN_OPEN_CNT - 4'h1))
                  begin
                     rx_state_reg <= IRBC_RX_WINDOW;
                     seen_reg <= 1'b0;
                  end
               end
            end
            IRBC_RX_WINDOW:
            begin
               if (fall)
               begin
                  rx_state_reg <= IRBC_RX_BIT;
                  rx_cnt_reg <= 4'h0;
                  bit_reg <= 1'b0;
               end
               else if (baud_tick)
               begin
                  rx_cnt_reg <= rx_cnt_reg + 4'h1;
                  // window closes at 8: bit is a one
                  if (irbc_at(rx_cnt_reg, `IRBC_RX_UPDATE_CNT - 4'h1))
                  begin
                     bit_reg <= 1'b1;
                     rx_state_reg <= IRBC_RX_IDLE;
                  end
               end
            end
            default:
               rx_state_reg <= IRBC_RX_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////
   // output updated at count 8, giving eight clock lag
   // only the codec realigns; the uart sees a plain line
   always_ff @(posedge clock)
   begin
      if (!rst_n || !codec_on_reg)
         rx_dec_reg <= 1'b1;
      else if (baud_tick && rx_state_reg != IRBC_RX_IDLE
               && irbc_at(rx_cnt_reg, `IRBC_RX_UPDATE_CNT - 4'h1))
         // a window closing without a pulse decodes a one, not the previous zero
         rx_dec_reg <= (rx_state_reg == IRBC_RX_BIT) ? bit_reg : 1'b1;
      else if (rx_state_reg == IRBC_RX_IDLE && baud_tick)
         rx_dec_reg <= 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // pin steering
   // pin function is enabled elsewhere after codec enable
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         serial_out_pin <= 1'b1;
         uart_rx <= 1'b1;
         rx_active <= 1'b0;
      end
      else
      begin
         serial_out_pin <= codec_on_reg ? ir_out : uart_tx;
         uart_rx <= codec_on_reg ? rx_dec_reg : serial_in_pin;
         rx_active <= rx_state_reg != IRBC_RX_IDLE;
      end
   end
endmodule // infrared_bit_codec

// File: irbc_defs.svh
// constants for the infrared bit codec
`ifndef IRBC_DEFS_SVH
`define IRBC_DEFS_SVH
`define IRBC_BIT_CLOCKS 5'd16
`define IRBC_CNT_MAX 4'hf
`define IRBC_TX_PULSE_START 4'h7
`define IRBC_TX_PULSE_END 4'ha
`define IRBC_RX_UPDATE_CNT 4'h8
`define IRBC_RX_WIN_OPEN_CNT 4'hc
`define IRBC_CLK_HZ 20000000
`define IRBC_MIN_RATE_BAUD 9600
`define IRBC_MAX_RATE_BAUD 115200
`endif

// File: irbc_pkg.sv
// types for the infrared bit codec
package irbc_pkg;
   typedef logic [3:0] irbc_count_t;
   typedef enum logic [1:0] {IRBC_RX_IDLE, IRBC_RX_BIT, IRBC_RX_WINDOW} irbc_rx_state_e;
   // count value decode shared by transmit and receive
   function automatic logic irbc_at(input logic [3:0] cnt, input logic [3:0] val);
      irbc_at = (cnt == val);
   endfunction
endpackage

// File: irbc_tick_if.sv
// baud tick and enable shared between codec halves
`timescale 1ns/10ps
interface irbc_tick_if;
   logic baud_tick;
   logic codec_on;
   logic tx_busy;
   modport src (output baud_tick, output codec_on, input tx_busy);
   modport sink (input baud_tick, input codec_on, output tx_busy);
endinterface // irbc_tick_if

// File: irbc_encoder.sv
// infrared transmit modulator
`include "irbc_defs.svh"
`timescale 1ns/10ps
module irbc_encoder
(
   input wire logic clock,
   input wire logic rst_n,
   irbc_tick_if.sink tick,
   input wire logic uart_tx,
   output logic infrared_modulated_out
);
   import irbc_pkg::*;
   irbc_count_t cnt_reg;
   logic bit_reg;
   logic busy_reg;
   ////////////////////////////////////////////////////////////
   // sixteen clocks per bit
   always_ff @(posedge clock)
   begin
      if (!rst_n || !tick.codec_on)
      begin
         cnt_reg <= 4'h0;
         bit_reg <= 1'b1;
         busy_reg <= 1'b0;
      end
      else if (tick.baud_tick)
      begin
         cnt_reg <= cnt_reg + 4'h1;
         if (irbc_at(cnt_reg, `IRBC_CNT_MAX))
         begin
            bit_reg <= uart_tx;
            busy_reg <= !uart_tx;
         end
         else if (cnt_reg == 4'h0 && !busy_reg)
            bit_reg <= uart_tx;
      end
   end
   ////////////////////////////////////////////////////////////
   // zero gives 7 low, 3 high, 6 low
   always_ff @(posedge clock)
   begin
      if (!rst_n || !tick.codec_on)
         infrared_modulated_out <= 1'b0;
      else if (tick.baud_tick)
      begin
         if (!bit_reg && irbc_at(cnt_reg, `IRBC_TX_PULSE_START - 4'h1))
            infrared_modulated_out <= 1'b1;
         else if (irbc_at(cnt_reg, `IRBC_TX_PULSE_END - 4'h1))
            infrared_modulated_out <= 1'b0;
      end
   end
   assign tick.tx_busy = !bit_reg;
endmodule // irbc_encoder

// File: irbc_props.sv
// port assertions for the infrared bit codec
`timescale 1ns/10ps
module irbc_props
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic uart_enable,
   input wire logic infrared_codec_enable,
   input wire logic baud_tick,
   input wire logic uart_tx,
   input wire logic uart_rx,
   input wire logic serial_in_pin,
   input wire logic serial_out_pin,
   input wire logic rx_active
);
   logic ir_on;
   logic [4:0] one_reg;
   logic [3:0] hi_reg;
   logic [3:0] rx_reg;
   assign ir_on = uart_enable && infrared_codec_enable;
   ////////////////////////////////////////////////////////////////
   // tick counters saturate so long idle runs never wrap
   always_ff @(posedge clock)
      one_reg <= (!rst_n || !ir_on || !uart_tx) ? 5'h0 : one_reg + {4'h0, baud_tick && one_reg != 5'h1f};
   always_ff @(posedge clock)
      hi_reg <= (!rst_n || !ir_on || !serial_out_pin) ? 4'h0 : hi_reg + {3'h0, baud_tick && hi_reg != 4'hf};
   always_ff @(posedge clock)
      rx_reg <= (!rst_n || !rx_active) ? 4'h0 : rx_reg + {3'h0, baud_tick && rx_reg != 4'hf};
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   sequence pass_out_s;
      (uart_enable && !infrared_codec_enable && $stable(uart_tx)) [*4];
   endsequence
   sequence pass_in_s;
      (uart_enable && !infrared_codec_enable && $stable(serial_in_pin)) [*4];
   endsequence
   sequence rx_idle_s;
      (ir_on && !rx_active) [*6];
   endsequence
   ////////////////////////////////////////////////////////////////
   reset_vals_a: assert property (disable iff (1'b0) !rst_n |=> serial_out_pin && uart_rx && !rx_active)
      else $error("reset levels wrong");
   pass_out_a: assert property (pass_out_s |-> serial_out_pin == uart_tx)
      else $error("transmit pass-through wrong");
   pass_in_a: assert property (pass_in_s |-> uart_rx == serial_in_pin)
      else $error("receive pass-through wrong");
   one_low_a: assert property (one_reg >= 5'd20 |-> !serial_out_pin)
      else $error("pulse sent for a one");
   zero_width_a: assert property ($fell(serial_out_pin) && $past(ir_on, 20) |-> hi_reg == 4'd3)
      else $error("zero pulse width wrong");
   rx_update_a: assert property ($fell(uart_rx) && ir_on |-> $past(baud_tick, 2))
      else $error("receive update off tick");
   rx_lag_a: assert property ($fell(uart_rx) && $past(ir_on, 20) |-> rx_reg == 4'd8)
      else $error("receive lag wrong");
   rx_idle_a: assert property (rx_idle_s |-> uart_rx)
      else $error("receive idle not high");
   half_duplex_a: assert property (ir_on && serial_out_pin |-> !$rose(rx_active))
      else $error("receive started during transmit");
endmodule // irbc_props

// File: irbc_partner.sv
// infrared transceiver model on the far side of the codec
`timescale 1ns/10ps
module irbc_partner
(
   input wire logic clock,
   input wire logic baud_tick,
   input wire logic tx_light,
   output logic rx_light
);
   initial rx_light = 1'b0;
   task automatic send(input logic [9:0] frame, input int pos);
      wait (tx_light === 1'b0);
      for (int b = 0; b < 10; b++)
         for (int t = 0; t < 16; t++)
         begin
            @(posedge clock iff baud_tick);
            @(negedge clock);
            rx_light = !frame[b] && t >= pos && t < pos + 3;
         end
   endtask
endmodule // irbc_partner

// File: test_infrared_bit_codec.sv
// self-checking bench for the infrared bit codec
`timescale 1ns/10ps
module test_infrared_bit_codec;
   logic clock, rst_n, uart_enable, infrared_codec_enable, baud_tick, uart_tx, uart_rx;
   logic serial_in_pin, serial_out_pin, rx_active, ir_mode, wire_rx, ir_light, out_q, rx_q;
   logic [1:0] tick_q = 2'h0;
   logic [9:0] frame;
   int n_fail = 0, n_compared = 0, cycles = 0;
   int exp_q[$];
   assign serial_in_pin = ir_mode ? ir_light : wire_rx;
   infrared_bit_codec u_dut (.clock(clock), .rst_n(rst_n), .uart_enable(uart_enable),
      .infrared_codec_enable(infrared_codec_enable), .baud_tick(baud_tick), .uart_tx(uart_tx), .uart_rx(uart_rx),
      .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .rx_active(rx_active));
   irbc_partner u_ir (.clock(clock), .baud_tick(baud_tick), .tx_light(serial_out_pin), .rx_light(ir_light));
   ////////////////////////////////////////////////////////////////
   task automatic give_verdict(input int extra);
      n_fail += extra;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string what, input int exp, input int seen);
      n_compared++;
      if (exp != seen)
      begin
         n_fail++;
         $display("mismatch %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task automatic note(input int kind, input logic cond);
      if (cond)
         exp_q.push_back(kind);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clock iff baud_tick);
      @(negedge clock);
   endtask
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // ticks four cycles apart keep pin edges clear of tick edges
   always @(negedge clock)
   begin
      tick_q <= tick_q + 2'h1;
      baud_tick <= tick_q == 2'h3;
      cycles++;
      if (cycles == 8000)
         give_verdict(1);
   end
   // event 1: transmit pin rises, event 2: receive line falls
   always @(negedge clock)
   begin
      if (rst_n === 1'b1 && out_q === 1'b0 && serial_out_pin === 1'b1)
         check("tx event", exp_q.size() > 0 ? exp_q.pop_front() : 0, 1);
      if (rst_n === 1'b1 && rx_q === 1'b1 && uart_rx === 1'b0)
         check("rx event", exp_q.size() > 0 ? exp_q.pop_front() : 0, 2);
      out_q <= serial_out_pin;
      rx_q <= uart_rx;
   end
   ////////////////////////////////////////////////////////////////
   initial
   begin
      {rst_n, uart_enable, infrared_codec_enable, uart_tx, ir_mode, wire_rx} = 6'h15;
      void'($urandom(32'had3c));
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      repeat (16)
      begin
         frame = 10'($urandom);
         note(1, !uart_tx && frame[0]);
         uart_tx = frame[0];
         repeat (4) @(negedge clock);
         note(2, wire_rx && !frame[1]);
         wire_rx = frame[1];
         repeat (4) @(negedge clock);
      end
      note(1, !uart_tx);
      uart_tx = 1'b1;
      repeat (4) @(negedge clock);
      note(2, wire_rx);
      ir_mode = 1'b1;
      repeat (4) @(negedge clock);
      infrared_codec_enable = 1'b1;
      ticks(20);
      frame = {1'b1, 8'($urandom), 1'b0};
      for (int b = 0; b < 10; b++)
      begin
         note(1, !frame[b]);
         uart_tx = frame[b];
         ticks(16);
      end
      ticks(24);
      // late pulses in the second frame probe the window
      for (int k = 0; k < 2; k++)
      begin
         frame = {1'b1, 8'($urandom), 1'b0};
         for (int b = 0; b < 10; b++)
            note(2, !frame[b] && (b == 0 || frame[b - 1]));
         u_ir.send(frame, 7 + 3 * k);
         ticks(30);
      end
      check("queue left", 0, exp_q.size());
      give_verdict(0);
   end
endmodule // test_infrared_bit_codec
bind infrared_bit_codec irbc_props u_props (.clock(clock), .rst_n(rst_n), .uart_enable(uart_enable),
   .infrared_codec_enable(infrared_codec_enable), .baud_tick(baud_tick), .uart_tx(uart_tx), .uart_rx(uart_rx),
   .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .rx_active(rx_active));
